// >>> mpvw_consts.svh
`ifndef MPVW_CONSTS_SVH
`define MPVW_CONSTS_SVH

// register indices (byte address is four times the index)
`define MPVW_IDX_PAUSE_CONTROL   4'h8
`define MPVW_IDX_TAG_PRIMARY     4'h9
`define MPVW_IDX_TAG_SECONDARY   4'ha
`define MPVW_IDX_WAKE_FILTER     4'hb
`define MPVW_ADDR_PAUSE_CONTROL  8'h20
`define MPVW_ADDR_TAG_PRIMARY    8'h24
`define MPVW_ADDR_TAG_SECONDARY  8'h28
`define MPVW_ADDR_WAKE_FILTER    8'h2c

// pause control fields
`define MPVW_PC_BUSY_BIT         0
`define MPVW_PC_ENABLE_BIT       1
`define MPVW_PC_PASS_BIT         2
`define MPVW_PC_TIME_LSB         16
`define MPVW_PC_TIME_MSB         31

// reset values
`define MPVW_RST_PAUSE_CONTROL   32'h0000_0000
`define MPVW_RST_TAG             16'h0000
`define MPVW_RST_FILTER_WORD     32'h0000_0000

// frame lengths and timing
`define MPVW_MAX_LEN_PLAIN       11'd1518
`define MPVW_MAX_LEN_TAGGED      11'd1522
`define MPVW_SLOT_TIME_NS        5120
`define MPVW_CLK_PERIOD_NS       20
`define MPVW_SLOT_CYCLES \
  ((`MPVW_SLOT_TIME_NS + `MPVW_CLK_PERIOD_NS - 1) / `MPVW_CLK_PERIOD_NS)
`define MPVW_FILTER_WORDS        8

`endif

// >>> mpvw_pkg.sv
package mpvw_pkg;
  typedef logic [31:0] mpvw_word_t;
  typedef logic [15:0] mpvw_tag_t;
  typedef enum logic [1:0] {
    MPVW_TX_IDLE,
    MPVW_TX_PAUSE_SEND,
    MPVW_TX_BACKPRESS
  } mpvw_tx_e;
endpackage

// >>> mpvw_filter_if.sv
`timescale 1ns/100ps
interface mpvw_filter_if #(parameter int DEPTH = 8);
  logic                     wr_en;
  logic [$clog2(DEPTH)-1:0] wr_idx;
  logic [31:0]              wr_data;
  logic [$clog2(DEPTH)-1:0] rd_idx;
  logic [31:0]              rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data,
                output rd_idx, input rd_data);
  modport mem (input wr_en, input wr_idx, input wr_data,
               input rd_idx, output rd_data);
endinterface

// >>> mpvw_filter_mem.sv
`timescale 1ns/100ps
`include "mpvw_consts.svh"
module mpvw_filter_mem #(
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic         mclk_in,
  input  wire logic         rst_in,
  // filter access
  mpvw_filter_if.mem        fif
);
  logic [31:0] word_reg [DEPTH];
  logic [31:0] rd_reg;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_word
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          word_reg[g] <= `MPVW_RST_FILTER_WORD;
        end else if (fif.wr_en && fif.wr_idx == g) begin
          word_reg[g] <= fif.wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_in) begin
    rd_reg <= word_reg[fif.rd_idx];
  end

  assign fif.rd_data = rd_reg;
endmodule

// >>> mpvw_top.sv
`timescale 1ns/100ps
`include "mpvw_consts.svh"
module mpvw_top #(
  parameter int FILTER_WORDS = `MPVW_FILTER_WORDS,
  parameter int SLOT_CYCLES  = `MPVW_SLOT_CYCLES
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // apb slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // link status and requests
  input  wire logic        full_duplex_in,
  input  wire logic        tx_enable_in,
  input  wire logic        pause_req_in,
  input  wire logic        backpress_req_in,
  // received frame bytes
  input  wire logic        rx_valid_in,
  input  wire logic        rx_sof_in,
  input  wire logic [7:0]  rx_byte_in,
  input  wire logic        rx_eof_in,
  input  wire logic        rx_ctrl_ok_in,
  // pause frame transmitter
  output logic             pause_frame_start_out,
  output logic      [15:0] pause_frame_time_out,
  input  wire logic        pause_frame_done_in,
  // mac datapath controls
  output logic             tx_stall_out,
  output logic             backpress_out,
  output logic             rx_tag_a_out,
  output logic             rx_tag_b_out,
  output logic      [10:0] rx_max_len_out,
  // wake filter read side
  input  wire logic [2:0]  filter_rd_idx_in,
  output logic      [31:0] filter_rd_data_out
);
  localparam int PW = $clog2(FILTER_WORDS);

  // registers
  logic                  fc_enable_reg;
  logic                  fc_pass_reg;
  logic [15:0]           fc_time_reg;
  mpvw_pkg::mpvw_tag_t   tag_a_reg;
  mpvw_pkg::mpvw_tag_t   tag_b_reg;
  logic [PW-1:0]         wptr_reg;
  logic [PW-1:0]         wptr_next;
  logic [31:0]           prdata_reg;
  mpvw_pkg::mpvw_tx_e    tx_state_reg;
  mpvw_pkg::mpvw_tx_e    tx_state_next;
  logic [15:0]           quanta_reg;
  logic [15:0]           slot_reg;
  logic [3:0]            rx_cnt_reg;
  logic [7:0]            rx_hi_reg;
  logic [7:0]            rx_pt_hi_reg;
  logic [15:0]           rx_pause_reg;
  logic                  rx_tag_a_reg;
  logic                  rx_tag_b_reg;
  logic [15:0]           pause_time_reg;
  logic                  pause_start_reg;

  // apb decode
  wire apb_access = psel_in && penable_in;
  wire apb_wr     = apb_access && pwrite_in;
  wire apb_rd     = apb_access && !pwrite_in;
  wire sel_pc     = paddr_in == `MPVW_ADDR_PAUSE_CONTROL;
  wire sel_ta     = paddr_in == `MPVW_ADDR_TAG_PRIMARY;
  wire sel_tb     = paddr_in == `MPVW_ADDR_TAG_SECONDARY;
  wire sel_wf     = paddr_in == `MPVW_ADDR_WAKE_FILTER;
  wire sel_any    = sel_pc || sel_ta || sel_tb || sel_wf;
  wire busy       = tx_state_reg != mpvw_pkg::MPVW_TX_IDLE;
  wire wf_write   = apb_wr && sel_wf;

  wire [31:0] pc_view = {fc_time_reg, 13'h0, fc_pass_reg,
                         fc_enable_reg, busy};
  wire [31:0] rd_mux =
      sel_pc ? pc_view :
      sel_ta ? {16'h0000, tag_a_reg} :
      sel_tb ? {16'h0000, tag_b_reg} :
      32'h0000_0000;

  assign pready_out  = 1'b1;
  assign pslverr_out = apb_access && !sel_any;
  assign prdata_out  = prdata_reg;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata_reg <= 32'h0000_0000;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_reg <= rd_mux;
    end
  end

  // register writes; busy bit position is ignored
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fc_enable_reg <= 1'(`MPVW_RST_PAUSE_CONTROL >> `MPVW_PC_ENABLE_BIT);
      fc_pass_reg   <= 1'b0;
      fc_time_reg   <= 16'h0000;
      tag_a_reg     <= `MPVW_RST_TAG;
      tag_b_reg     <= `MPVW_RST_TAG;
    end else if (apb_wr) begin
      if (sel_pc) begin
        fc_enable_reg <= pwdata_in[`MPVW_PC_ENABLE_BIT];
        fc_pass_reg   <= pwdata_in[`MPVW_PC_PASS_BIT];
        fc_time_reg   <= pwdata_in[`MPVW_PC_TIME_MSB:`MPVW_PC_TIME_LSB];
      end
      if (sel_ta) begin
        tag_a_reg <= pwdata_in[15:0];
      end
      if (sel_tb) begin
        tag_b_reg <= pwdata_in[15:0];
      end
    end
  end

  // wake filter write pointer
  assign wptr_next = (wptr_reg == PW'(FILTER_WORDS - 1)) ? '0
                   : wptr_reg + PW'(1);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wptr_reg <= '0;
    end else if (wf_write) begin
      wptr_reg <= wptr_next;
    end
  end

  mpvw_filter_if #(.DEPTH(FILTER_WORDS)) fif ();
  assign fif.wr_en   = wf_write;
  assign fif.wr_idx  = wptr_reg;
  assign fif.wr_data = pwdata_in;
  assign fif.rd_idx  = PW'(filter_rd_idx_in);
  assign filter_rd_data_out = fif.rd_data;

  mpvw_filter_mem #(.DEPTH(FILTER_WORDS)) u_mem (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .fif     (fif)
  );

  // receive parse: bytes 13-14 tag, pause time at bytes 15-16
  wire decode_on  = fc_enable_reg && full_duplex_in;
  wire rx_byte14  = rx_valid_in && rx_cnt_reg == 4'd13;
  wire rx_byte18  = rx_valid_in && rx_cnt_reg == 4'd15 + 4'd0;
  wire [15:0] rx_tag_word = {rx_hi_reg, rx_byte_in};
  // pause time including the byte arriving with end of frame
  wire [15:0] rx_pause_now = rx_byte18 ? {rx_pt_hi_reg, rx_byte_in}
                                       : rx_pause_reg;

  always_ff @(posedge mclk_in) begin
    if (rst_in || (rx_valid_in && rx_sof_in)) begin
      rx_cnt_reg   <= (rx_valid_in && rx_sof_in) ? 4'd1 : 4'd0;
      rx_hi_reg    <= 8'h00;
      rx_pt_hi_reg <= 8'h00;
      rx_pause_reg <= 16'h0000;
      rx_tag_a_reg <= 1'b0;
      rx_tag_b_reg <= 1'b0;
    end else if (rx_valid_in) begin
      if (rx_cnt_reg != 4'hf) begin
        rx_cnt_reg <= rx_cnt_reg + 4'd1;
      end
      rx_hi_reg <= rx_byte_in;
      if (rx_byte14) begin
        rx_tag_a_reg <= rx_tag_word == tag_a_reg;
        rx_tag_b_reg <= rx_tag_word == tag_b_reg;
      end
      if (rx_cnt_reg == 4'd14) begin
        rx_pt_hi_reg <= rx_byte_in;
      end
      if (rx_byte18) begin
        rx_pause_reg <= {rx_pt_hi_reg, rx_byte_in};
      end
    end
  end

  assign rx_tag_a_out   = rx_tag_a_reg;
  assign rx_tag_b_out   = rx_tag_b_reg;
  assign rx_max_len_out = (rx_tag_a_reg || rx_tag_b_reg)
                        ? `MPVW_MAX_LEN_TAGGED
                        : `MPVW_MAX_LEN_PLAIN;

  // received pause: stall for quanta x slot
  wire pause_rx = decode_on && rx_valid_in && rx_eof_in && rx_ctrl_ok_in;

  always_ff @(posedge mclk_in) begin
    if (rst_in || !decode_on) begin
      quanta_reg <= 16'h0000;
      slot_reg   <= 16'h0000;
    end else if (pause_rx) begin
      quanta_reg <= rx_pause_now;
      slot_reg   <= 16'(SLOT_CYCLES - 1);
    end else if (quanta_reg != 16'h0000) begin
      if (slot_reg == 16'h0000) begin
        quanta_reg <= quanta_reg - 16'd1;
        slot_reg   <= 16'(SLOT_CYCLES - 1);
      end else begin
        slot_reg <= slot_reg - 16'd1;
      end
    end
  end

  assign tx_stall_out = quanta_reg != 16'h0000;

  // pause send / backpressure busy state
  always_comb begin
    tx_state_next = tx_state_reg;
    case (tx_state_reg)
      mpvw_pkg::MPVW_TX_IDLE: begin
        if (fc_enable_reg && tx_enable_in) begin
          if (full_duplex_in && pause_req_in) begin
            tx_state_next = mpvw_pkg::MPVW_TX_PAUSE_SEND;
          end else if (!full_duplex_in && backpress_req_in) begin
            tx_state_next = mpvw_pkg::MPVW_TX_BACKPRESS;
          end
        end
      end
      mpvw_pkg::MPVW_TX_PAUSE_SEND: begin
        if (pause_frame_done_in) begin
          tx_state_next = mpvw_pkg::MPVW_TX_IDLE;
        end
      end
      mpvw_pkg::MPVW_TX_BACKPRESS: begin
        if (!backpress_req_in || !fc_enable_reg || full_duplex_in) begin
          tx_state_next = mpvw_pkg::MPVW_TX_IDLE;
        end
      end
      default: tx_state_next = mpvw_pkg::MPVW_TX_IDLE;
    endcase
  end

  wire start_pause = tx_state_reg == mpvw_pkg::MPVW_TX_IDLE &&
                     tx_state_next == mpvw_pkg::MPVW_TX_PAUSE_SEND;

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tx_state_reg    <= mpvw_pkg::MPVW_TX_IDLE;
      pause_start_reg <= 1'b0;
      pause_time_reg  <= 16'h0000;
    end else begin
      tx_state_reg    <= tx_state_next;
      pause_start_reg <= start_pause;
      if (start_pause) begin
        pause_time_reg <= fc_time_reg;
      end
    end
  end

  assign pause_frame_start_out = pause_start_reg;
  assign pause_frame_time_out  = pause_time_reg;
  assign backpress_out = tx_state_reg == mpvw_pkg::MPVW_TX_BACKPRESS;

  // assertions
  default clocking a_cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_pause_sending;
    tx_state_reg == mpvw_pkg::MPVW_TX_PAUSE_SEND && !pause_frame_done_in;
  endsequence
  sequence s_pause_finishing;
    tx_state_reg == mpvw_pkg::MPVW_TX_PAUSE_SEND && pause_frame_done_in;
  endsequence

  a_busy_reads_state: assert property (
    (psel_in && !penable_in && !pwrite_in && sel_pc && busy)
    |=> prdata_out[0]) else $error("busy bit not shown");
  a_busy_held_frame: assert property (
    s_pause_sending |=> busy) else $error("busy dropped early");
  a_busy_clears_done: assert property (
    s_pause_finishing |=> !busy) else $error("busy not cleared");
  a_no_decode_off: assert property (
    !decode_on |=> !tx_stall_out) else $error("stall while off");
  a_pause_stalls: assert property (
    (pause_rx && rx_pause_now != 16'h0000) |=> tx_stall_out ##1
    (tx_stall_out || !$past(decode_on)))
    else $error("pause not stalling");
  a_half_backpress: assert property (
    backpress_out |-> !full_duplex_in || $past(!full_duplex_in))
    else $error("backpressure in full duplex");
  a_tag_len: assert property (
    (rx_tag_a_out || rx_tag_b_out)
    |-> rx_max_len_out == `MPVW_MAX_LEN_TAGGED)
    else $error("tagged length wrong");
  a_tag_match: assert property (
    rx_byte14 && !rx_sof_in |=> rx_tag_a_out == ($past(rx_tag_word)
    == $past(tag_a_reg))) else $error("tag compare wrong");
  a_ptr_advance: assert property (
    wf_write |=> wptr_reg == $past(wptr_next))
    else $error("pointer not advanced");
  a_ptr_read_hold: assert property (
    !wf_write |=> $stable(wptr_reg)) else $error("pointer moved");
  a_wf_read_zero: assert property (
    (psel_in && !penable_in && !pwrite_in && sel_wf) |=> prdata_out == '0)
    else $error("filter read not zero");
  a_pause_time: assert property (
    pause_frame_start_out |-> pause_frame_time_out == $past(fc_time_reg))
    else $error("pause time wrong");
endmodule

// >>> mpvw_tx_partner.sv
`timescale 1ns/100ps
module mpvw_tx_partner (
  // clock and reset
  input  wire logic       mclk_in,
  input  wire logic       rst_in,
  // frame sender handshake
  input  wire logic       start_in,
  input  wire logic [7:0] delay_in,
  output logic            done_out
);
  logic [8:0] count_reg;

  // sends a frame for delay_in + 1 cycles, then pulses done
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      count_reg <= 9'h000;
      done_out  <= 1'b0;
    end else begin
      done_out <= (count_reg == 9'h001);
      if (start_in) begin
        count_reg <= {1'b0, delay_in} + 9'h001;
      end else if (count_reg != 9'h000) begin
        count_reg <= count_reg - 9'h001;
      end
    end
  end
endmodule

// >>> testbench.sv
`timescale 1ns/100ps
`include "mpvw_consts.svh"
module testbench;
  localparam int SLOT = 4;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel_in = 1'b0;
  logic        penable_in = 1'b0;
  logic        pwrite_in = 1'b0;
  logic [7:0]  paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0;
  logic [31:0] prdata_out;
  logic        pready_out;
  logic        pslverr_out;
  logic        full_duplex_in = 1'b1;
  logic        tx_enable_in = 1'b1;
  logic        pause_req_in = 1'b0;
  logic        backpress_req_in = 1'b0;
  logic        rx_valid_in = 1'b0;
  logic        rx_sof_in = 1'b0;
  logic [7:0]  rx_byte_in = 8'h00;
  logic        rx_eof_in = 1'b0;
  logic        rx_ctrl_ok_in = 1'b0;
  logic        pause_frame_start_out;
  logic [15:0] pause_frame_time_out;
  logic        pause_frame_done_in;
  logic        tx_stall_out;
  logic        backpress_out;
  logic        rx_tag_a_out;
  logic        rx_tag_b_out;
  logic [10:0] rx_max_len_out;
  logic [2:0]  filter_rd_idx_in = 3'h0;
  logic [31:0] filter_rd_data_out;
  logic [7:0]  delay = 8'h14;
  int          bad_count = 0;
  int          compares = 0;
  int          stall_n = 0;

  mpvw_top #(.SLOT_CYCLES(SLOT)) i_mpvw_top (
    .mclk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .full_duplex_in,
    .tx_enable_in, .pause_req_in, .backpress_req_in, .rx_valid_in,
    .rx_sof_in, .rx_byte_in, .rx_eof_in, .rx_ctrl_ok_in,
    .pause_frame_start_out, .pause_frame_time_out, .pause_frame_done_in,
    .tx_stall_out, .backpress_out, .rx_tag_a_out, .rx_tag_b_out,
    .rx_max_len_out, .filter_rd_idx_in, .filter_rd_data_out
  );

  mpvw_tx_partner i_mpvw_tx_partner (
    .mclk_in  (mclk_in),
    .rst_in   (rst_in),
    .start_in (pause_frame_start_out),
    .delay_in (delay),
    .done_out (pause_frame_done_in)
  );

  always #10 mclk_in = ~mclk_in;

  // counts transmitter hold-off cycles
  always @(posedge mclk_in) begin
    if (tx_stall_out === 1'b1) begin
      stall_n++;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    @(posedge mclk_in);
    psel_in    <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in  <= w;
    paddr_in   <= a;
    pwdata_in  <= d;
    @(posedge mclk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready_out !== 1'b1);
    r = prdata_out;
    e = pslverr_out;
    psel_in    <= 1'b0;
    penable_in <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x);
  endtask

  // sixteen-byte frame: tag in bytes 13-14, tail in bytes 15-16
  task automatic frame(input logic [15:0] tag, input logic [15:0] tl,
                       input logic ok);
    for (int i = 1; i <= 16; i++) begin
      @(posedge mclk_in);
      rx_valid_in   <= 1'b1;
      rx_sof_in     <= (i == 1);
      rx_eof_in     <= (i == 16);
      rx_ctrl_ok_in <= ok && (i == 16);
      rx_byte_in    <= (i == 13) ? tag[15:8] : (i == 14) ? tag[7:0] :
                       (i == 15) ? tl[15:8] : (i == 16) ? tl[7:0] : 8'(i);
    end
    @(posedge mclk_in);
    rx_valid_in   <= 1'b0;
    rx_eof_in     <= 1'b0;
    rx_ctrl_ok_in <= 1'b0;
    rx_byte_in    <= ~rx_byte_in;
    repeat (3) @(posedge mclk_in);
  endtask

  task automatic print_verdict;
    if (bad_count == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    bad_count++;
    print_verdict;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h0);
    rd(`MPVW_ADDR_TAG_PRIMARY, 32'h0);
    rd(`MPVW_ADDR_TAG_SECONDARY, 32'h0);
    rd(`MPVW_ADDR_WAKE_FILTER, 32'h0);
    chk(32'(rx_max_len_out), 32'(`MPVW_MAX_LEN_PLAIN));
    apb(1'b1, 8'h3c, 32'h5a5a_5a5a, r, e);
    chk(32'(e), 32'h1);
    // tag detection, both classes and none
    wr(`MPVW_ADDR_TAG_PRIMARY, 32'hffff_8100);
    rd(`MPVW_ADDR_TAG_PRIMARY, 32'h0000_8100);
    frame(16'h8100, 16'h0000, 1'b0);
    chk(32'({rx_tag_a_out, rx_tag_b_out}), 32'h2);
    chk(32'(rx_max_len_out), 32'(`MPVW_MAX_LEN_TAGGED));
    wr(`MPVW_ADDR_TAG_PRIMARY, 32'h0000_0000);
    wr(`MPVW_ADDR_TAG_SECONDARY, 32'h0000_8100);
    rd(`MPVW_ADDR_TAG_SECONDARY, 32'h0000_8100);
    frame(16'h8100, 16'h0000, 1'b0);
    chk(32'({rx_tag_a_out, rx_tag_b_out}), 32'h1);
    chk(32'(rx_max_len_out), 32'(`MPVW_MAX_LEN_TAGGED));
    frame(16'h0800, 16'h0000, 1'b0);
    chk(32'({rx_tag_a_out, rx_tag_b_out}), 32'h0);
    chk(32'(rx_max_len_out), 32'(`MPVW_MAX_LEN_PLAIN));
    // nine filter writes, a read in between
    for (int i = 0; i < 9; i++) begin
      wr(`MPVW_ADDR_WAKE_FILTER, 32'h0000_0f00 + i);
      if (i == 3) begin
        rd(`MPVW_ADDR_WAKE_FILTER, 32'h0);
      end
    end
    for (int i = 0; i < 8; i++) begin
      filter_rd_idx_in <= 3'(i);
      repeat (2) @(posedge mclk_in);
      chk(filter_rd_data_out, (i == 0) ? 32'hf08 : 32'hf00 + i);
    end
    // pause frame send with slow far side
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h0);
    wr(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0002);
    pause_req_in <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pause_frame_start_out !== 1'b1);
    pause_req_in <= 1'b0;
    chk(32'(pause_frame_time_out), 32'h1234);
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0003);
    repeat (30) @(posedge mclk_in);
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0002);
    // received pause, enabled then disabled
    stall_n = 0;
    frame(16'h8808, 16'h0002, 1'b1);
    repeat (40) @(posedge mclk_in);
    chk(32'(stall_n), 32'(2 * SLOT));
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0002);
    wr(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0000);
    stall_n = 0;
    frame(16'h8808, 16'h0002, 1'b1);
    repeat (40) @(posedge mclk_in);
    chk(32'(stall_n), 32'h0);
    // half duplex backpressure
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0000);
    wr(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0002);
    full_duplex_in   <= 1'b0;
    backpress_req_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk(32'(backpress_out), 32'h1);
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0003);
    backpress_req_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    chk(32'(backpress_out), 32'h0);
    rd(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0002);
    wr(`MPVW_ADDR_PAUSE_CONTROL, 32'h1234_0000);
    backpress_req_in <= 1'b1;
    repeat (4) @(posedge mclk_in);
    chk(32'(backpress_out), 32'h0);
    backpress_req_in <= 1'b0;
    print_verdict;
  end
endmodule
